// File: rtl/wrsp_pkg.sv
// Shared constants and types for working-register addressing and the system stack.
package wrsp_pkg;
  localparam int AXI_AW = 12;

  // Register indices; the bus byte address is four times the index.
  localparam logic [7:0] IDX_SLICE_A = 8'hD6;
  localparam logic [7:0] IDX_SLICE_B = 8'hD7;
  localparam logic [7:0] IDX_SP_HI   = 8'hD8;
  localparam logic [7:0] IDX_SP_LO   = 8'hD9;
  localparam logic [AXI_AW-1:0] ADDR_SLICE_A = {2'h0, IDX_SLICE_A, 2'h0};
  localparam logic [AXI_AW-1:0] ADDR_SLICE_B = {2'h0, IDX_SLICE_B, 2'h0};
  localparam logic [AXI_AW-1:0] ADDR_SP_HI   = {2'h0, IDX_SP_HI, 2'h0};
  localparam logic [AXI_AW-1:0] ADDR_SP_LO   = {2'h0, IDX_SP_LO, 2'h0};

  localparam logic [7:0] SLICE_A_RST = 8'hC0;
  localparam logic [7:0] SLICE_B_RST = 8'hC8;
  localparam logic [3:0] ESC_NIBBLE  = 4'hC;
  localparam int         SEL_BIT     = 3;
  localparam int         OFS_W       = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    op_push                = 4'h0,
    op_pop                 = 4'h1,
    op_call                = 4'h2,
    subroutine_exit_op     = 4'h3,
    interrupt_entry_op     = 4'h4,
    interrupt_exit_op      = 4'h5,
    user_push_incrementing = 4'h6,
    user_push_decrementing = 4'h7,
    user_pop_incrementing  = 4'h8,
    user_pop_decrementing  = 4'h9
  } stack_op_t;

  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_push = 4'b0010,
    st_pop  = 4'b0100,
    st_fin  = 4'b1000
  } stack_state_t;

  typedef struct packed {
    logic       short_form;
    logic [7:0] operand;
  } opnd_req_t;

  typedef struct packed {
    stack_op_t  op;
    logic [15:0] pc;
    logic [7:0] flags;
    logic [7:0] data;
    logic [7:0] user_ptr;
  } stack_req_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] flags;
    logic [7:0] data;
    logic [7:0] user_ptr;
  } stack_rsp_t;

  typedef struct packed {
    logic [1:0] count;
    logic       push;
    logic       user;
    logic       up;
  } stack_plan_t;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rf_cmd_t;
endpackage

// File: rtl/wr_addr_former.sv
// Combinational forming of a register-file address from an instruction operand.
`timescale 1ns/1ps
`default_nettype none
module wr_addr_former (
  input  wire logic [7:0]          slice_pointer_a,
  input  wire logic [7:0]          slice_pointer_b,
  input  wire wrsp_pkg::opnd_req_t req,
  output logic [7:0]               reg_addr
);
  function automatic logic [7:0] work_addr(input logic [3:0] nib,
                                           input logic [7:0] pa,
                                           input logic [7:0] pb);
    logic [7:0] ptr;
    ptr = nib[wrsp_pkg::SEL_BIT] ? pb : pa;
    return {ptr[7:wrsp_pkg::OFS_W], nib[wrsp_pkg::OFS_W-1:0]};
  endfunction

  wire logic is_esc = (req.operand[7:4] == wrsp_pkg::ESC_NIBBLE);

  assign reg_addr = (req.short_form || is_esc)
                  ? work_addr(req.operand[3:0], slice_pointer_a, slice_pointer_b)
                  : req.operand;
endmodule
`default_nettype wire

// File: rtl/stack_plan.sv
// Decode of a stack operation into byte count, direction and pointer kind.
`timescale 1ns/1ps
`default_nettype none
module stack_plan (
  input  wire wrsp_pkg::stack_op_t   op,
  output var  wrsp_pkg::stack_plan_t plan
);
  always_comb begin
    plan = '0;
    case (op)
      wrsp_pkg::op_push:                plan = '{2'h1, 1'h1, 1'h0, 1'h0};
      wrsp_pkg::op_pop:                 plan = '{2'h1, 1'h0, 1'h0, 1'h0};
      wrsp_pkg::op_call:                plan = '{2'h2, 1'h1, 1'h0, 1'h0};
      wrsp_pkg::subroutine_exit_op:     plan = '{2'h2, 1'h0, 1'h0, 1'h0};
      wrsp_pkg::interrupt_entry_op:     plan = '{2'h3, 1'h1, 1'h0, 1'h0};
      wrsp_pkg::interrupt_exit_op:      plan = '{2'h3, 1'h0, 1'h0, 1'h0};
      wrsp_pkg::user_push_incrementing: plan = '{2'h1, 1'h1, 1'h1, 1'h1};
      wrsp_pkg::user_push_decrementing: plan = '{2'h1, 1'h1, 1'h1, 1'h0};
      wrsp_pkg::user_pop_incrementing:  plan = '{2'h1, 1'h0, 1'h1, 1'h1};
      wrsp_pkg::user_pop_decrementing:  plan = '{2'h1, 1'h0, 1'h1, 1'h0};
      default:                          plan = '0;
    endcase
  end
endmodule
`default_nettype wire

// File: rtl/wreg_stack_core.sv
// Working-register address forming, system and user stack engine, AXI4-Lite registers.
// Contract
// - operand bit 3 picks slice pointer a or b.
// - pointer upper five bits form address top.
// - operand low three bits form address bottom.
// - escape nibble 1100B means working-register reference.
// - escaped form uses bit 3 to pick pointer.
// - push decrements pointer, then writes byte.
// - pop reads byte, then increments pointer.
// - pointer always addresses current stack top.
// - call saves counter, return restores it.
// - interrupt pushes counter and flags; exit pops.
// - pointer high byte at D8H, low D9H.
// - reset leaves stack pointer undefined.
// - low byte wrap carries into high byte.
// - four user stack push and pop operations.
// - plain addressing uses full address, no pointer.
// - slice pointers readable and writable at D6H/D7H.
// - reset selects slices C0H and C8H.
`timescale 1ns/1ps
`default_nettype none
module wreg_stack_core (
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  input  wire logic [11:0]             awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [11:0]             araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire logic                    opnd_valid,
  input  wire wrsp_pkg::opnd_req_t     opnd,
  output logic                         addr_valid,
  output logic [7:0]                   reg_addr,
  input  wire logic                    stack_valid,
  output logic                         stack_ready,
  input  wire wrsp_pkg::stack_req_t    stack_req,
  output logic                         stack_done,
  output var wrsp_pkg::stack_rsp_t     stack_rsp,
  output var wrsp_pkg::rf_cmd_t        rf_cmd,
  input  wire logic [7:0]              rf_rdata
);

  function automatic logic [3:0] map_sel(input logic [11:0] a);
    return {a == wrsp_pkg::ADDR_SP_LO, a == wrsp_pkg::ADDR_SP_HI,
            a == wrsp_pkg::ADDR_SLICE_B, a == wrsp_pkg::ADDR_SLICE_A};
  endfunction

  logic [7:0]  slice_pointer_a;
  logic [7:0]  slice_pointer_b;
  logic [15:0] system_stack_pointer;
  wire logic [7:0] stack_pointer_high_byte = system_stack_pointer[15:8];
  wire logic [7:0] stack_pointer_low_byte  = system_stack_pointer[7:0];

  // Operand address path.
  logic [7:0] next_reg_addr;

  wr_addr_former u_addr (
    .slice_pointer_a (slice_pointer_a),
    .slice_pointer_b (slice_pointer_b),
    .req             (opnd),
    .reg_addr        (next_reg_addr)
  );

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_valid <= 1'b0;
      reg_addr   <= 8'h00;
    end else begin
      addr_valid <= opnd_valid;
      if (opnd_valid) begin
        reg_addr <= next_reg_addr;
      end
    end
  end

  // AXI4-Lite write channel state.
  logic [11:0] aw_q;
  logic [7:0]  wd_q;
  logic        ws_q;

  wire logic       wr_fire = !awready && !wready && !bvalid;
  wire logic [3:0] wr_hit  = map_sel(aw_q);
  wire logic [3:0] wr_sel  = wr_hit & {4{wr_fire && ws_q}};
  wire logic [3:0] rd_sel  = map_sel(araddr);
  wire logic [7:0] rd_byte = ({8{rd_sel[0]}} & slice_pointer_a)
                           | ({8{rd_sel[1]}} & slice_pointer_b)
                           | ({8{rd_sel[2]}} & stack_pointer_high_byte)
                           | ({8{rd_sel[3]}} & stack_pointer_low_byte);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      aw_q    <= 12'h000;
      wd_q    <= 8'h00;
      ws_q    <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_q    <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wd_q   <= wdata[7:0];
        ws_q   <= wstrb[0];
        wready <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= (|wr_hit) ? wrsp_pkg::RESP_OKAY : wrsp_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= 2'h0;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= {24'h00_0000, rd_byte};
        rresp   <= (|rd_sel) ? wrsp_pkg::RESP_OKAY : wrsp_pkg::RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      slice_pointer_a <= wrsp_pkg::SLICE_A_RST;
      slice_pointer_b <= wrsp_pkg::SLICE_B_RST;
    end else begin
      if (wr_sel[0]) begin
        slice_pointer_a <= wd_q;
      end
      if (wr_sel[1]) begin
        slice_pointer_b <= wd_q;
      end
    end
  end

  // Stack engine.
  wrsp_pkg::stack_state_t state;
  wrsp_pkg::stack_plan_t  plan;
  wrsp_pkg::stack_plan_t  cur;
  logic [1:0]  left;
  logic [23:0] shift;
  logic [7:0]  uptr;
  logic        rd_pend;

  stack_plan u_plan (
    .op   (stack_req.op),
    .plan (plan)
  );

  wire logic        accept    = stack_valid && stack_ready;
  wire logic        step_push = (state == wrsp_pkg::st_push);
  wire logic        step_pop  = (state == wrsp_pkg::st_pop);
  wire logic        sys_step  = (step_push || step_pop) && !cur.user;
  wire logic        last      = (left == 2'h1);
  wire logic [15:0] sp_dec    = system_stack_pointer - 16'h0001;
  wire logic [15:0] sp_inc    = system_stack_pointer + 16'h0001;
  wire logic [7:0]  uptr_step = cur.up ? uptr + 8'h01 : uptr - 8'h01;
  wire logic [7:0]  push_addr = cur.user ? uptr_step : sp_dec[7:0];
  wire logic [7:0]  pop_addr  = cur.user ? uptr : stack_pointer_low_byte;
  wire logic [23:0] load_val  =
      (stack_req.op == wrsp_pkg::interrupt_entry_op) ? {stack_req.flags, stack_req.pc} :
      (stack_req.op == wrsp_pkg::op_call) ? {8'h00, stack_req.pc} :
      {16'h0000, stack_req.data};

  // The pointer is data, not control, so it carries no reset value at all.
  // top kept, left unreset.
  always_ff @(posedge sys_clk) begin
    if (sys_step) begin
      system_stack_pointer <= step_push ? sp_dec : sp_inc;
    end else begin
      if (wr_sel[2]) begin
        system_stack_pointer[15:8] <= wd_q;
      end
      if (wr_sel[3]) begin
        system_stack_pointer[7:0] <= wd_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= wrsp_pkg::st_idle;
      stack_ready <= 1'b1;
      stack_done  <= 1'b0;
      stack_rsp   <= '0;
      rf_cmd      <= '0;
      cur         <= '0;
      left        <= 2'h0;
      shift       <= 24'h00_0000;
      uptr        <= 8'h00;
      rd_pend     <= 1'b0;
    end else begin
      stack_done <= 1'b0;
      rf_cmd.we  <= 1'b0;
      rf_cmd.re  <= 1'b0;
      rd_pend    <= rf_cmd.re;
      if (rd_pend) begin
        shift <= {shift[15:0], rf_rdata};
      end
      case (state)
        wrsp_pkg::st_idle: begin
          if (accept) begin
            cur         <= plan;
            left        <= plan.count;
            shift       <= load_val;
            uptr        <= stack_req.user_ptr;
            stack_ready <= 1'b0;
            state       <= plan.push ? wrsp_pkg::st_push : wrsp_pkg::st_pop;
          end
        end
        wrsp_pkg::st_push: begin
          rf_cmd.we    <= 1'b1;
          rf_cmd.addr  <= push_addr;
          rf_cmd.wdata <= shift[7:0];
          shift        <= {8'h00, shift[23:8]};
          uptr         <= cur.user ? uptr_step : uptr;
          left         <= left - 2'h1;
          if (last) begin
            state <= wrsp_pkg::st_fin;
          end
        end
        wrsp_pkg::st_pop: begin
          rf_cmd.re   <= 1'b1;
          rf_cmd.addr <= pop_addr;
          uptr        <= cur.user ? uptr_step : uptr;
          left        <= left - 2'h1;
          if (last) begin
            state <= wrsp_pkg::st_fin;
          end
        end
        wrsp_pkg::st_fin: begin
          if (!rf_cmd.re && !rd_pend) begin
            state       <= wrsp_pkg::st_idle;
            stack_ready <= 1'b1;
            stack_done  <= 1'b1;
            stack_rsp   <= '{shift[15:0], shift[23:16], shift[7:0], uptr};
          end
        end
        default: begin
          state <= wrsp_pkg::st_idle;
        end
      endcase
    end
  end

  // Checks.
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  wire logic [7:0] exp_a   = {slice_pointer_a[7:3], opnd.operand[2:0]};
  wire logic [7:0] exp_w   = opnd.operand[3]
                           ? {slice_pointer_b[7:3], opnd.operand[2:0]} : exp_a;
  wire logic [7:0] op_byte = opnd.operand;
  wire logic       op_esc  = (opnd.operand[7:4] == wrsp_pkg::ESC_NIBBLE);
  wire logic       is_op   = accept;
  wire logic [3:0] req_op  = stack_req.op;

  a_short_sel_a: assert property (
    opnd_valid && opnd.short_form && !opnd.operand[3]
    |=> addr_valid && reg_addr == $past(exp_a))
    else $error("short operand did not use pointer a");

  a_short_work: assert property (
    opnd_valid && opnd.short_form |=> reg_addr == $past(exp_w))
    else $error("short operand address wrong");

  a_esc_form: assert property (
    opnd_valid && !opnd.short_form && op_esc |=> reg_addr == $past(exp_w))
    else $error("escaped operand address wrong");

  a_direct_pass: assert property (
    opnd_valid && !opnd.short_form && !op_esc |=> reg_addr == $past(op_byte))
    else $error("plain operand was altered");

  a_push_top: assert property (
    rf_cmd.we && !cur.user |-> rf_cmd.addr == stack_pointer_low_byte)
    else $error("push byte not at new top");

  a_pop_after: assert property (
    rf_cmd.re && !cur.user |-> stack_pointer_low_byte == rf_cmd.addr + 8'h01)
    else $error("pop did not step past read byte");

  a_sp_borrow: assert property (
    sys_step && step_push && stack_pointer_low_byte == 8'h00
    |=> stack_pointer_high_byte == $past(stack_pointer_high_byte) - 8'h01)
    else $error("borrow missed high byte");

  a_call_frame: assert property (
    is_op && req_op == wrsp_pkg::op_call |-> ##4 stack_done
    && system_stack_pointer == $past(system_stack_pointer, 4) - 16'h0002)
    else $error("call frame wrong");

  a_irq_frame: assert property (
    is_op && req_op == wrsp_pkg::interrupt_exit_op |-> ##7 stack_done
    && system_stack_pointer == $past(system_stack_pointer, 7) + 16'h0003)
    else $error("interrupt return frame wrong");

  a_user_step: assert property (
    is_op && req_op == wrsp_pkg::user_push_incrementing |-> ##3 stack_done
    && stack_rsp.user_ptr == $past(stack_req.user_ptr, 3) + 8'h01)
    else $error("user pointer step wrong");

  a_slice_write: assert property (
    wr_sel[1] |=> slice_pointer_b == $past(wd_q) && bvalid)
    else $error("slice pointer write lost");

  a_sp_readback: assert property (
    arvalid && arready && araddr == wrsp_pkg::ADDR_SP_HI
    |=> rvalid && rdata[7:0] == $past(stack_pointer_high_byte))
    else $error("high byte read-back wrong");

  c_call: cover property (is_op && req_op == wrsp_pkg::op_call ##4 stack_done);
  c_interrupt_exit_op: cover property (is_op && req_op == wrsp_pkg::interrupt_exit_op);
  c_esc: cover property (opnd_valid && !opnd.short_form && op_esc);
  c_axi_wr: cover property (bvalid && bready && bresp == wrsp_pkg::RESP_OKAY);
endmodule
`default_nettype wire

// File: tb/rf_model.sv
// Behavioural register file that answers the stack engine's reads.
`timescale 1ns/1ps
`default_nettype none
module rf_model (
  input  wire logic              sys_clk,
  input  wire wrsp_pkg::rf_cmd_t rf_cmd,
  output logic [7:0]             rf_rdata
);
  logic [7:0] mem [256];
  logic [7:0] rdata_q = 8'hA5;

  // Read data is valid for one cycle; in the next it toggles, so a sample one cycle late never passes.
  always @(posedge sys_clk) begin
    if (rf_cmd.we) begin
      mem[rf_cmd.addr] <= rf_cmd.wdata;
    end
    if (rf_cmd.re) begin
      rdata_q <= mem[rf_cmd.addr];
    end else begin
      rdata_q <= ~rdata_q;
    end
  end

  assign rf_rdata = rdata_q;
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for working-register addressing and the stack engine.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic       sf;
    logic [7:0] opv;
    logic [7:0] exp;
  } row_t;

  logic                 sys_clk     = 1'h0;
  logic                 arst_n      = 1'h0;
  logic [11:0]          awaddr      = 12'h000;
  logic                 awvalid     = 1'h0;
  logic [31:0]          wdata       = 32'h0;
  logic [3:0]           wstrb       = 4'hF;
  logic                 wvalid      = 1'h0;
  logic                 bready      = 1'h0;
  logic [11:0]          araddr      = 12'h000;
  logic                 arvalid     = 1'h0;
  logic                 rready      = 1'h0;
  logic                 opnd_valid  = 1'h0;
  wrsp_pkg::opnd_req_t  opnd        = '0;
  logic                 stack_valid = 1'h0;
  wrsp_pkg::stack_req_t stack_req   = '0;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic                 addr_valid, stack_ready, stack_done;
  logic [1:0]           bresp, rresp;
  logic [31:0]          rdata;
  logic [7:0]           reg_addr, rf_rdata;
  wrsp_pkg::stack_rsp_t stack_rsp, r;
  wrsp_pkg::rf_cmd_t    rf_cmd;
  int                   mismatches = 0;
  int                   n_compared = 0;

  // Pointers are 75h and ADh, so their low three bits must be dropped.
  row_t rows [7] = '{
    '{1'h1, 8'h06, 8'h76},
    '{1'h1, 8'h0B, 8'hAB},
    '{1'h1, 8'hF5, 8'h75},
    '{1'h0, 8'hCB, 8'hAB},
    '{1'h0, 8'hC2, 8'h72},
    '{1'h0, 8'h5E, 8'h5E},
    '{1'h0, 8'hD8, 8'hD8}
  };

  always #2.5 sys_clk = ~sys_clk;

  wreg_stack_core wreg_stack_core_inst (
    .sys_clk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .opnd_valid, .opnd, .addr_valid, .reg_addr, .stack_valid, .stack_ready,
    .stack_req, .stack_done, .stack_rsp, .rf_cmd, .rf_rdata
  );

  rf_model rf_model_inst (
    .sys_clk  (sys_clk),
    .rf_cmd   (rf_cmd),
    .rf_rdata (rf_rdata)
  );

  task automatic stop_test;
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 40) begin
      mismatches++;
      $display("[ERR] handshake expected within 40 cycles seen none");
      stop_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 40);
    bready <= 1'h0;
    tmo(n);
    chk("bresp", 32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 40);
    rready <= 1'h0;
    tmo(n);
    chk("rdata", rdata, {24'h0, d});
    chk("rresp", 32'(rresp), 32'(er));
  endtask

  // The latency figure is the edge at which done is sampled, counted from the take.
  task automatic stk(input wrsp_pkg::stack_op_t op, input logic [15:0] pc,
                     input logic [7:0] fl, input logic [7:0] dt, input logic [7:0] up,
                     input int lat);
    int n;
    n = 0;
    stack_req <= '{op: op, pc: pc, flags: fl, data: dt, user_ptr: up};
    stack_valid <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (stack_ready !== 1'h1 && n < 40);
    stack_valid <= 1'h0;
    tmo(n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (stack_done !== 1'h1 && n < 40);
    tmo(n);
    chk("latency", 32'(n), 32'(lat));
    r = stack_rsp;
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'h1;
    rd(wrsp_pkg::ADDR_SLICE_A, 8'hC0, wrsp_pkg::RESP_OKAY);
    rd(wrsp_pkg::ADDR_SLICE_B, 8'hC8, wrsp_pkg::RESP_OKAY);
    rd(12'h000, 8'h00, wrsp_pkg::RESP_SLVERR);
    wr(12'h3F0, 8'h55, wrsp_pkg::RESP_SLVERR);
    wr(wrsp_pkg::ADDR_SLICE_A, 8'h75, wrsp_pkg::RESP_OKAY);
    wr(wrsp_pkg::ADDR_SLICE_B, 8'hAD, wrsp_pkg::RESP_OKAY);
    // A write with its low lane disabled must leave the pointer alone.
    wstrb <= 4'h0;
    wr(wrsp_pkg::ADDR_SLICE_A, 8'h11, wrsp_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    rd(wrsp_pkg::ADDR_SLICE_A, 8'h75, wrsp_pkg::RESP_OKAY);
    rd(wrsp_pkg::ADDR_SLICE_B, 8'hAD, wrsp_pkg::RESP_OKAY);
    $display("test registers done");
    foreach (rows[i]) begin
      opnd <= '{short_form: rows[i].sf, operand: rows[i].opv};
      opnd_valid <= 1'h1;
      @(posedge sys_clk);
      opnd_valid <= 1'h0;
      @(posedge sys_clk);
      chk("addr_valid", 32'(addr_valid), 32'h1);
      chk("reg_addr", 32'(reg_addr), 32'(rows[i].exp));
    end
    $display("test operands done");
    // The pointer is undefined after reset, so software loads it first.
    wr(wrsp_pkg::ADDR_SP_HI, 8'h01, wrsp_pkg::RESP_OKAY);
    wr(wrsp_pkg::ADDR_SP_LO, 8'h00, wrsp_pkg::RESP_OKAY);
    stk(wrsp_pkg::op_push, 16'h0, 8'h0, 8'h77, 8'h0, 3);
    chk("push_byte", 32'(rf_model_inst.mem[8'hFF]), 32'h77);
    rd(wrsp_pkg::ADDR_SP_HI, 8'h00, wrsp_pkg::RESP_OKAY);
    rd(wrsp_pkg::ADDR_SP_LO, 8'hFF, wrsp_pkg::RESP_OKAY);
    stk(wrsp_pkg::op_pop, 16'h0, 8'h0, 8'h0, 8'h0, 5);
    chk("pop_data", 32'(r.data), 32'h77);
    rd(wrsp_pkg::ADDR_SP_HI, 8'h01, wrsp_pkg::RESP_OKAY);
    rd(wrsp_pkg::ADDR_SP_LO, 8'h00, wrsp_pkg::RESP_OKAY);
    $display("test push pop done");
    wr(wrsp_pkg::ADDR_SP_HI, 8'h3C, wrsp_pkg::RESP_OKAY);
    wr(wrsp_pkg::ADDR_SP_LO, 8'hFF, wrsp_pkg::RESP_OKAY);
    stk(wrsp_pkg::op_call, 16'h1234, 8'h0, 8'h0, 8'h0, 4);
    chk("call_lo", 32'(rf_model_inst.mem[8'hFE]), 32'h34);
    chk("call_hi", 32'(rf_model_inst.mem[8'hFD]), 32'h12);
    rd(wrsp_pkg::ADDR_SP_LO, 8'hFD, wrsp_pkg::RESP_OKAY);
    stk(wrsp_pkg::subroutine_exit_op, 16'h0, 8'h0, 8'h0, 8'h0, 6);
    chk("ret_pc", 32'(r.pc), 32'h1234);
    stk(wrsp_pkg::interrupt_entry_op, 16'hABCD, 8'h5A, 8'h0, 8'h0, 5);
    chk("entry_flags", 32'(rf_model_inst.mem[8'hFC]), 32'h5A);
    stk(wrsp_pkg::interrupt_exit_op, 16'h0, 8'h0, 8'h0, 8'h0, 7);
    chk("exit_pc", 32'(r.pc), 32'hABCD);
    chk("exit_flags", 32'(r.flags), 32'h5A);
    rd(wrsp_pkg::ADDR_SP_HI, 8'h3C, wrsp_pkg::RESP_OKAY);
    rd(wrsp_pkg::ADDR_SP_LO, 8'hFF, wrsp_pkg::RESP_OKAY);
    $display("test call interrupt done");
    stk(wrsp_pkg::user_push_incrementing, 16'h0, 8'h0, 8'h11, 8'h40, 3);
    chk("upi_ptr", 32'(r.user_ptr), 32'h41);
    chk("upi_byte", 32'(rf_model_inst.mem[8'h41]), 32'h11);
    stk(wrsp_pkg::user_push_decrementing, 16'h0, 8'h0, 8'h22, 8'h41, 3);
    chk("upd_ptr", 32'(r.user_ptr), 32'h40);
    chk("upd_byte", 32'(rf_model_inst.mem[8'h40]), 32'h22);
    stk(wrsp_pkg::user_pop_incrementing, 16'h0, 8'h0, 8'h0, 8'h40, 5);
    chk("uopi", 32'({r.data, r.user_ptr}), 32'h2241);
    stk(wrsp_pkg::user_pop_decrementing, 16'h0, 8'h0, 8'h0, 8'h41, 5);
    chk("uopd", 32'({r.data, r.user_ptr}), 32'h1140);
    rd(wrsp_pkg::ADDR_SP_LO, 8'hFF, wrsp_pkg::RESP_OKAY);
    $display("test user stack done");
    arst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'h1;
    rd(wrsp_pkg::ADDR_SLICE_A, 8'hC0, wrsp_pkg::RESP_OKAY);
    $display("test second reset done");
    stop_test();
  end
endmodule
`default_nettype wire
